// ===== src/vpcs_pkg.sv
// Purpose : constants and types for the per-virtual-processor config and scheduling registers
// Assumes : registers are reached by coprocessor-0 style select numbers, 32-bit data
// Notes   : field positions, reset values and codes are named once here
//
// Behaviour
// - resource config read-only unless config write enabled
// - bits 27:20 report preset udi context count
// - bits 17:10 report preset cop2 context count
// - bits 7:0 report preset cop1 context count
// - resource config unused bits read zero
// - yield mask 31 bits, reset zero, bit31 zero
// - illegal positive yield qualifier raises exception code 3
// - mask bits of missing qualifier inputs tied zero
// - schedule hint resets to zero default
// - vproc hint divides core, thread hint divides vproc
// - feedback register shows retired count since cleared
// - options bits 15:8 exclude icache ways 7..0
// - exclusion acts only when partitioning supported and enabled
// - exclusion blocks allocation only, hits still served
// - bits of absent ways read as zero
// - exception sub-code kept in thread control 18:16
package vpcs_pkg;

    // ------------------------------------------------------------------
    // register selects
    // ------------------------------------------------------------------
    localparam logic [2:0] VPCS_SEL_THREAD_CTRL = 3'h1;  // thread control select
    localparam logic [2:0] VPCS_SEL_RES_CFG     = 3'h3;  // resource config select
    localparam logic [2:0] VPCS_SEL_YQ_MASK     = 3'h4;  // yield qualifier mask select
    localparam logic [2:0] VPCS_SEL_SCHED_HINT  = 3'h5;  // schedule hint select
    localparam logic [2:0] VPCS_SEL_SCHED_FB    = 3'h6;  // schedule feedback select
    localparam logic [2:0] VPCS_SEL_OPTIONS     = 3'h7;  // options select

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int VPCS_UDI_LSB    = 20;  // udi context count 27:20
    localparam int VPCS_COP2_LSB   = 10;  // cop2 context count 17:10
    localparam int VPCS_COP1_LSB   = 0;   // cop1 context count 7:0
    localparam int VPCS_COUNT_W    = 8;   // width of each count
    localparam int VPCS_EXC_LSB    = 16;  // exception sub-code 18:16
    localparam int VPCS_EXC_W      = 3;
    localparam int VPCS_IWX_LSB    = 8;   // icache way exclude 15:8
    localparam int VPCS_WAYS_MAX   = 8;
    localparam int VPCS_YQ_W       = 31;  // mask width, bit 31 reserved

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [30:0] VPCS_YQ_RESET    = 31'h0;
    localparam logic [31:0] VPCS_HINT_RESET  = 32'h0;
    localparam logic [31:0] VPCS_FB_RESET    = 32'h0;
    localparam logic [7:0]  VPCS_IWX_RESET   = 8'h0;
    localparam logic [2:0]  VPCS_EXC_RESET   = 3'h0;
    localparam logic [2:0]  VPCS_EXC_BAD_YQ  = 3'h3;  // illegal qualifier sub-code

    // yield check progress
    typedef enum logic [1:0] {VPCS_YQ_IDLE, VPCS_YQ_FAULT} vpcs_yq_state_t;

endpackage

// ===== src/vpcs_cfg_if.sv
`timescale 1ns/1ps
// Purpose : carries the options and partitioning state to the allocation helper
// Assumes : single clock domain
// Notes   : way_exclude and part_active written by the register top, alloc_allowed written by the way gate
interface vpcs_cfg_if;
    logic [7:0] way_exclude;    // stored exclusion bits
    logic       part_active;    // partitioning supported and enabled
    logic [7:0] alloc_allowed;  // ways the allocator may fill
    modport regs (output way_exclude, output part_active, input alloc_allowed);
    modport gate (input way_exclude, input part_active, output alloc_allowed);
endinterface

// ===== src/vpcs_way_gate.sv
`timescale 1ns/1ps
// Purpose : turn exclusion bits into an allocation permit per way
// Assumes : lookups are not gated here at all
// Notes   : combinational; hits in excluded ways stay legal
module vpcs_way_gate (
    vpcs_cfg_if.gate cfg
);
    import vpcs_pkg::*;

    // ------------------------------------------------------------------
    // allocation permit
    // ------------------------------------------------------------------
    // only allocation is masked; hit paths never see this
    always_comb begin
        if (cfg.part_active) begin
            cfg.alloc_allowed = ~cfg.way_exclude;
        end else begin
            cfg.alloc_allowed = 8'hFF;
        end
    end
endmodule

// ===== src/vpcs_qual_check.sv
`timescale 1ns/1ps
// Purpose : decide whether a yield qualifier is legal against the mask
// Assumes : operand is presented with a one-cycle valid
// Notes   : combinational; the top registers the result
module vpcs_qual_check (
    input  wire logic        yield_valid,
    input  wire logic [31:0] qual_operand,
    input  wire logic [30:0] mask,
    output logic             illegal
);
    // positive means sign bit clear and nonzero
    logic positive;  // qualifier form applies

    // ------------------------------------------------------------------
    // legality test
    // ------------------------------------------------------------------
    always_comb begin
        positive = !qual_operand[31] && (qual_operand[30:0] != 31'h0);
        illegal  = yield_valid && positive && ((qual_operand[30:0] & ~mask) != 31'h0);
    end
endmodule

// ===== src/vpcs_regs.sv
`timescale 1ns/1ps
// Purpose : per-virtual-processor resource, yield mask, schedule and options registers
// Assumes : move-to/move-from requests are single-cycle strobes with a select number
// Notes   : read data registered one cycle after the read strobe
module vpcs_regs #(
    parameter int         QUAL_INPUTS = 31,  // implemented qualifier inputs
    parameter int         IC_WAYS     = 8,   // implemented icache ways
    parameter logic [7:0] UDI_COUNT   = 8'h01,
    parameter logic [7:0] COP2_COUNT  = 8'h01,
    parameter logic [7:0] COP1_COUNT  = 8'h01,
    parameter bit         PART_CAP    = 1'b1  // partitioning supported
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [2:0]  reg_sel,
    input  wire logic [31:0] wr_data,
    output logic [31:0]      rd_data,
    input  wire logic        config_write_enable,
    input  wire logic        part_enable,
    output logic             partition_capable,
    input  wire logic        yield_valid,
    input  wire logic [31:0] qualifier_operand,
    output logic             thread_exc,
    output logic [2:0]       thread_exc_subcode,
    input  wire logic        retire_pulse,
    output logic [31:0]      vproc_schedule_hint,
    output logic [7:0]       icache_alloc_allowed
);
    import vpcs_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]     udi_cnt;     // udi context count
        logic [7:0]     cop2_cnt;    // cop2 context count
        logic [7:0]     cop1_cnt;    // cop1 context count
        logic [30:0]    yq_mask;     // yield qualifier mask
        logic [31:0]    hint;        // schedule hint
        logic [31:0]    feedback;    // retired count
        logic [7:0]     iwx;         // icache way exclude
        logic [2:0]     exc_code;    // last thread exception sub-code
        logic           exc_pulse;   // exception strobe
        vpcs_yq_state_t yq_state;    // fault marker
        logic [31:0]    rdata;       // read data
        logic           preset_done; // counts loaded after reset
    } vpcs_state_t;

    vpcs_state_t st_reg;   // registered state
    vpcs_state_t st_next;  // next state

    logic [30:0] qual_impl_mask;  // implemented qualifier inputs
    logic [7:0]  way_impl_mask;   // implemented ways
    logic        bad_qual;        // illegal qualifier seen

    vpcs_cfg_if cfg ();

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // absent qualifier inputs and ways become constant zero bits
    always_comb begin
        qual_impl_mask = '0;
        way_impl_mask  = '0;
        for (int i = 0; i < VPCS_YQ_W; i++) begin
            qual_impl_mask[i] = (i < QUAL_INPUTS);
        end
        for (int i = 0; i < VPCS_WAYS_MAX; i++) begin
            way_impl_mask[i] = (i < IC_WAYS);
        end
    end

    vpcs_qual_check u_qual (
        .yield_valid  (yield_valid),
        .qual_operand (qualifier_operand),
        .mask         (st_reg.yq_mask),
        .illegal      (bad_qual)
    );

    assign cfg.way_exclude = st_reg.iwx;
    assign cfg.part_active = PART_CAP && part_enable;

    vpcs_way_gate u_gate (
        .cfg (cfg.gate)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next           = st_reg;
        st_next.exc_pulse = 1'b0;
        st_next.yq_state  = VPCS_YQ_IDLE;
        // presets are loaded by a clock edge, never by the reset itself
        if (!st_reg.preset_done) begin
            st_next.udi_cnt     = UDI_COUNT;
            st_next.cop2_cnt    = COP2_COUNT;
            st_next.cop1_cnt    = COP1_COUNT;
            st_next.preset_done = 1'b1;
        end
        // retire counting; a software write below wins in the same cycle
        if (retire_pulse) begin
            st_next.feedback = st_reg.feedback + 32'h1;
        end
        if (wr_en) begin
            unique case (reg_sel)
                VPCS_SEL_RES_CFG: begin
                    // ignored unless configuration writes are enabled
                    if (config_write_enable) begin
                        st_next.udi_cnt  = wr_data[VPCS_UDI_LSB +: VPCS_COUNT_W];
                        st_next.cop2_cnt = wr_data[VPCS_COP2_LSB +: VPCS_COUNT_W];
                        st_next.cop1_cnt = wr_data[VPCS_COP1_LSB +: VPCS_COUNT_W];
                    end
                end
                VPCS_SEL_YQ_MASK: begin
                    st_next.yq_mask = wr_data[30:0] & qual_impl_mask;
                end
                VPCS_SEL_SCHED_HINT: begin
                    st_next.hint = wr_data;
                end
                VPCS_SEL_SCHED_FB: begin
                    st_next.feedback = wr_data;
                end
                VPCS_SEL_OPTIONS: begin
                    st_next.iwx = wr_data[VPCS_IWX_LSB +: 8] & way_impl_mask;
                end
                default: begin
                    // thread control and unmapped selects ignore writes
                end
            endcase
        end
        // illegal yield qualifier
        if (bad_qual) begin
            st_next.exc_code  = VPCS_EXC_BAD_YQ;
            st_next.exc_pulse = 1'b1;
            st_next.yq_state  = VPCS_YQ_FAULT;
        end
        // read mux
        if (rd_en) begin
            unique case (reg_sel)
                VPCS_SEL_THREAD_CTRL: begin
                    st_next.rdata = {13'h0, st_next.exc_code, 16'h0};
                end
                VPCS_SEL_RES_CFG: begin
                    st_next.rdata = {4'h0, st_reg.udi_cnt, 2'h0,
                                     st_reg.cop2_cnt, 2'h0, st_reg.cop1_cnt};
                end
                VPCS_SEL_YQ_MASK: begin
                    st_next.rdata = {1'b0, st_reg.yq_mask};
                end
                VPCS_SEL_SCHED_HINT: begin
                    st_next.rdata = st_reg.hint;
                end
                VPCS_SEL_SCHED_FB: begin
                    st_next.rdata = st_reg.feedback;
                end
                VPCS_SEL_OPTIONS: begin
                    st_next.rdata = {16'h0, st_reg.iwx, 8'h0};
                end
                default: begin
                    st_next.rdata = 32'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{udi_cnt: 8'h0, cop2_cnt: 8'h0, cop1_cnt: 8'h0,
                        yq_mask: VPCS_YQ_RESET, hint: VPCS_HINT_RESET,
                        feedback: VPCS_FB_RESET, iwx: VPCS_IWX_RESET,
                        exc_code: VPCS_EXC_RESET, exc_pulse: 1'b0,
                        yq_state: VPCS_YQ_IDLE, rdata: 32'h0, preset_done: 1'b0};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // the scheduler splits core bandwidth by this hint first, then by thread
    assign vproc_schedule_hint  = st_reg.hint;
    assign rd_data              = st_reg.rdata;
    assign thread_exc           = st_reg.exc_pulse;
    assign thread_exc_subcode   = st_reg.exc_code;
    assign partition_capable    = PART_CAP;
    assign icache_alloc_allowed = cfg.alloc_allowed & way_impl_mask;
endmodule

// ===== test/vpcs_checker.sv
// Purpose : port-level checks of the vproc config and scheduling registers
// Assumes : one clock domain, async active-low reset
// Notes   : sees only top-level ports; bound at the foot of this file
`timescale 1ns/1ps
module vpcs_checker
    import vpcs_pkg::*;
#(
    parameter int QUAL_INPUTS = 31,  // implemented qualifier inputs
    parameter int IC_WAYS     = 8,   // implemented icache ways
    parameter bit PART_CAP    = 1'b1 // partitioning supported
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        wr_en,
    input wire logic [2:0]  reg_sel,
    input wire logic [31:0] wr_data,
    input wire logic        part_enable,
    input wire logic        partition_capable,
    input wire logic        yield_valid,
    input wire logic [31:0] qualifier_operand,
    input wire logic        thread_exc,
    input wire logic [2:0]  thread_exc_subcode,
    input wire logic [31:0] vproc_schedule_hint,
    input wire logic [7:0]  icache_alloc_allowed
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    localparam logic [7:0]  WAY_MASK  = 8'((9'h1 << IC_WAYS) - 9'h1);    // real ways
    localparam logic [30:0] QUAL_MASK = 31'((32'h1 << QUAL_INPUTS) - 32'h1);
    logic hint_wr;  // hint write taken this edge
    assign hint_wr = clk_en && wr_en && (reg_sel == VPCS_SEL_SCHED_HINT);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // a positive qualifier touching a missing input can never be legal
    sequence s_bad_yield;
        clk_en && yield_valid && !qualifier_operand[31]
            && |(qualifier_operand[30:0] & ~QUAL_MASK);
    endsequence
    sequence s_exc_seen;
        thread_exc && (thread_exc_subcode == VPCS_EXC_BAD_YQ);
    endsequence

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_bad_yield_exc: assert property (s_bad_yield |=> s_exc_seen)
        else $error("missing-input qualifier gave no exception");
    a_exc_has_cause: assert property ($rose(thread_exc) |-> $past(yield_valid && clk_en))
        else $error("exception without a yield");
    a_nonpos_quiet: assert property (clk_en && yield_valid && (qualifier_operand[31]
        || qualifier_operand == 32'h0) |=> !thread_exc)
        else $error("non-positive qualifier raised exception");
    a_subcode_cause: assert property ($changed(thread_exc_subcode) |-> thread_exc)
        else $error("subcode moved without exception");
    a_alloc_plain: assert property (!(PART_CAP && part_enable)
        |-> icache_alloc_allowed == WAY_MASK)
        else $error("exclusion acted while partitioning off");
    a_alloc_absent: assert property ((icache_alloc_allowed & ~WAY_MASK) == 8'h00)
        else $error("absent way offered for allocation");
    a_cap_flag: assert property (partition_capable == PART_CAP)
        else $error("partition capability flag wrong");
    a_hint_load: assert property (hint_wr |=> vproc_schedule_hint == $past(wr_data))
        else $error("hint write not seen on port");
    a_hint_keep: assert property (!hint_wr |=> $stable(vproc_schedule_hint))
        else $error("hint changed without write");
    a_freeze_exc: assert property (!clk_en |=> $stable({thread_exc, thread_exc_subcode}))
        else $error("exception outputs moved while clock enable low");
endmodule

bind vpcs_regs vpcs_checker #(
    .QUAL_INPUTS(QUAL_INPUTS),
    .IC_WAYS    (IC_WAYS),
    .PART_CAP   (PART_CAP)
) vpcs_checker_inst (.sys_clk, .rst_n, .clk_en, .wr_en, .reg_sel, .wr_data, .part_enable,
    .partition_capable, .yield_valid, .qualifier_operand, .thread_exc, .thread_exc_subcode,
    .vproc_schedule_hint, .icache_alloc_allowed);

// ===== test/tb.sv
// Purpose : directed register and yield tests of vpcs_regs
// Assumes : 28 qualifier inputs and 6 icache ways to reach tied-zero bits
// Notes   : answers sampled 1 ns after the edge that registers them
`timescale 1ns/1ps
module tb;
    import vpcs_pkg::*;
    localparam logic [31:0] CFG = {4'h0, 8'hA5, 2'h0, 8'h3C, 2'h0, 8'h81}; // preset view
    logic        sys_clk, rst_n, clk_en, wr_en, rd_en, cfg_we, part_en, yv, rp, exc, cap;
    logic [2:0]  reg_sel, sub;
    logic [31:0] wd, op, rdd, hint;
    logic [7:0]  alloc;
    int          n_errors, cmp_count;

    vpcs_regs #(.QUAL_INPUTS(28), .IC_WAYS(6), .UDI_COUNT(8'hA5), .COP2_COUNT(8'h3C),
        .COP1_COUNT(8'h81)) vpcs_regs_inst (.sys_clk, .rst_n, .clk_en,
        .wr_en, .rd_en, .reg_sel, .wr_data(wd), .rd_data(rdd), .config_write_enable(cfg_we),
        .part_enable(part_en), .partition_capable(cap), .yield_valid(yv),
        .qualifier_operand(op), .thread_exc(exc), .thread_exc_subcode(sub),
        .retire_pulse(rp), .vproc_schedule_hint(hint), .icache_alloc_allowed(alloc));

    // ------------------------------------------------------------------
    // clock and access tasks
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        reg_sel <= s;
        wd <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    // read answer lands on the edge after the strobe
    task automatic rchk(input string nm, input logic [2:0] s, input logic [31:0] exp);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        reg_sel <= s;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        chk(nm, rdd, exp);
    endtask
    task automatic yl(input logic [31:0] q, input logic e);
        @(posedge sys_clk);
        yv <= 1'b1;
        op <= q;
        @(posedge sys_clk);
        yv <= 1'b0;
        #1;
        chk("thread_exc", {31'h0, exc}, {31'h0, e});
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard: far beyond the directed run length
    initial begin
        #100000;
        n_errors++;
        tally_and_finish;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n, wr_en, rd_en, cfg_we, part_en, yv, rp, reg_sel, wd, op} = '0;
        clk_en = 1'b1;
        n_errors = 0;
        cmp_count = 0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rchk("res_cfg", VPCS_SEL_RES_CFG, CFG);
        rchk("yq_mask", VPCS_SEL_YQ_MASK, 32'h0);
        rchk("hint", VPCS_SEL_SCHED_HINT, 32'h0);
        rchk("feedback", VPCS_SEL_SCHED_FB, 32'h0);
        rchk("options", VPCS_SEL_OPTIONS, 32'h0);
        rchk("unmapped", 3'h0, 32'h0);
        chk("alloc", {24'h0, alloc}, 32'h3F);
        $display("reset values done");
        wr(VPCS_SEL_RES_CFG, 32'hFFFFFFFF);
        rchk("res_locked", VPCS_SEL_RES_CFG, CFG);
        cfg_we <= 1'b1;
        wr(VPCS_SEL_RES_CFG, 32'hFFFFFFFF);
        cfg_we <= 1'b0;
        rchk("res_open", VPCS_SEL_RES_CFG, 32'h0FF3FCFF);
        $display("resource config done");
        wr(VPCS_SEL_YQ_MASK, 32'hFFFFFFFF);
        rchk("yq_full", VPCS_SEL_YQ_MASK, 32'h0FFFFFFF);
        yl(32'h10000000, 1'b1);
        yl(32'h08000000, 1'b0);
        wr(VPCS_SEL_YQ_MASK, 32'h5);
        yl(32'h2, 1'b1);
        chk("subcode", {29'h0, sub}, 32'h3);
        // clock enable low must hold the exception strobe where it stands
        clk_en <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("exc_frozen", {31'h0, exc}, 32'h1);
        clk_en <= 1'b1;
        rchk("thr_ctrl", VPCS_SEL_THREAD_CTRL, 32'h3 << 16);
        yl(32'h4, 1'b0);
        yl(32'h80000002, 1'b0);
        yl(32'h0, 1'b0);
        $display("yield qualifier done");
        wr(VPCS_SEL_SCHED_HINT, 32'h12345678);
        #1;
        chk("hint_port", hint, 32'h12345678);
        rchk("hint_rd", VPCS_SEL_SCHED_HINT, 32'h12345678);
        // a write taken while the clock enable is low must be lost
        clk_en <= 1'b0;
        wr(VPCS_SEL_SCHED_HINT, 32'hFFFFFFFF);
        clk_en <= 1'b1;
        #1;
        chk("hint_frozen", hint, 32'h12345678);
        @(posedge sys_clk);
        rp <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rp <= 1'b0;
        rchk("fb_count", VPCS_SEL_SCHED_FB, 32'h3);
        wr(VPCS_SEL_SCHED_FB, 32'h0);
        rchk("fb_clear", VPCS_SEL_SCHED_FB, 32'h0);
        $display("schedule registers done");
        wr(VPCS_SEL_OPTIONS, 32'hFFFFFFFF);
        rchk("opt_full", VPCS_SEL_OPTIONS, 32'h00003F00);
        #1;
        chk("alloc_off", {24'h0, alloc}, 32'h3F);
        // keep some ways open before partitioning is switched on
        wr(VPCS_SEL_OPTIONS, 32'h00000500);
        part_en <= 1'b1;
        #1;
        chk("alloc_on", {24'h0, alloc}, 32'h3A);
        chk("cap", {31'h0, cap}, 32'h1);
        $display("way exclusion done");
        tally_and_finish;
    end
endmodule
